// file: verilog/smc_pkg.sv
`default_nettype none
package smc_pkg;
  // ------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------
  localparam int          LEN_W       = 32;
  localparam logic [31:0] HDR_BYTES   = 32'h0000_000A;
  localparam logic [31:0] LEN_FIRST   = 32'h0000_0002;
  localparam logic [31:0] LEN_LAST    = 32'h0000_0005;
  localparam logic [7:0]  STATUS_WAIT = 8'h00;
  localparam logic [7:0]  STATUS_DATA = 8'h01;
  localparam logic [7:0]  ACCEPT_BYTE = 8'h40;
  localparam logic [7:0]  FILL_BYTE   = 8'hFF;

  // ------------------------------------------------------------
  // synchroniser lanes on the device side
  // ------------------------------------------------------------
  localparam int SY_RX   = 0;
  localparam int SY_TAKE = 1;
  localparam int SY_CS   = 2;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_NS       = 25;
  localparam int SCLK_HALF_NS = 100;
  localparam int CS_SETUP_NS  = 200;
  localparam int CS_GAP_NS    = 200;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int CS_SETUP_CYC  = (CS_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CS_GAP_CYC    = (CS_GAP_NS + CLK_NS - 1) / CLK_NS;

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    D_IDLE  = 3'h0,
    D_RXCMD = 3'h1,
    D_EXEC  = 3'h2,
    D_TXRSP = 3'h3,
    D_ACC   = 3'h4
  } smc_dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_CMD  = 3'h1,
    H_POLL = 3'h2,
    H_READ = 3'h3,
    H_ACC  = 3'h4
  } smc_host_state_t;

  // ------------------------------------------------------------
  // length field helpers, shared by both ends
  // ------------------------------------------------------------
  function automatic logic [31:0] smc_len_next(input logic [31:0] cnt,
                                               input logic [31:0] len,
                                               input logic [7:0]  b);
    if (cnt >= LEN_FIRST && cnt <= LEN_LAST) begin
      return {len[23:0], b};
    end
    return len;
  endfunction

  // a length below the header size still ends after the header
  function automatic logic smc_is_last(input logic [31:0] cnt1,
                                       input logic [31:0] len);
    return (cnt1 >= HDR_BYTES) && (cnt1 >= len);
  endfunction
endpackage
`default_nettype wire

// file: verilog/smc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface smc_link_if;
  logic sclk;
  logic csN;
  logic mosi;
  logic miso;
  modport host (output sclk, output csN, output mosi, input miso);
  modport dev  (input sclk, input csN, input mosi, output miso);
endinterface
`default_nettype wire

// file: verilog/smc_byte_engine.sv
`timescale 1ns/1ps
`default_nettype none
module smc_byte_engine #(
  parameter int HALF_CYC = smc_pkg::SCLK_HALF_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic [7:0] txByte,
  input  wire logic       miso,
  output logic            busy,
  output logic            done,
  output logic [7:0]      rxByte,
  output logic            sclk,
  output logic            mosi
);
  // miso is sampled through two flops, so a half period needs headroom
  if (HALF_CYC < 3 || HALF_CYC > 255) begin : g_chk
    $error("HALF_CYC out of range");
  end

  localparam logic [7:0] HALF_LD = 8'(HALF_CYC - 1);

  logic [1:0] miSync_q;
  logic [7:0] txSh_q;
  logic [7:0] rxSh_q;
  logic [2:0] bit_q;
  logic [7:0] half_q;
  logic       fin_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      miSync_q <= 2'h0;
    end else if (ce) begin
      miSync_q <= {miSync_q[0], miso};
    end
  end

  // ------------------------------------------------------------
  // mode: drive on rising edge, sample on falling edge
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy   <= 1'b0;
      done   <= 1'b0;
      rxByte <= 8'h00;
      sclk   <= 1'b0;
      mosi   <= 1'b0;
      txSh_q <= 8'h00;
      rxSh_q <= 8'h00;
      bit_q  <= 3'h0;
      half_q <= 8'h00;
      fin_q  <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (!busy) begin
        if (start) begin
          busy   <= 1'b1;
          sclk   <= 1'b1;
          mosi   <= txByte[7];
          txSh_q <= {txByte[6:0], 1'b0};
          bit_q  <= 3'h0;
          half_q <= HALF_LD;
        end
      end else if (half_q != 8'h00) begin
        half_q <= half_q - 8'h01;
      end else if (sclk) begin
        sclk   <= 1'b0;
        half_q <= HALF_LD;
        rxSh_q <= {rxSh_q[6:0], miSync_q[1]};
        bit_q  <= bit_q + 3'h1;
        fin_q  <= (bit_q == 3'h7);
      end else if (fin_q) begin
        // trailing low half keeps the next chip select edge clear of the last bit
        fin_q  <= 1'b0;
        busy   <= 1'b0;
        done   <= 1'b1;
        rxByte <= rxSh_q;
      end else begin
        sclk   <= 1'b1;
        mosi   <= txSh_q[7];
        txSh_q <= {txSh_q[6:0], 1'b0};
        half_q <= HALF_LD;
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/smc_host_end.sv
`timescale 1ns/1ps
`default_nettype none
module smc_host_end #(
  parameter int SETUP_CYC = smc_pkg::CS_SETUP_CYC,
  parameter int GAP_CYC   = smc_pkg::CS_GAP_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  smc_link_if.host        link,
  input  wire logic [7:0] cmdData,
  input  wire logic       cmdValid,
  output logic            cmdTaken,
  output logic [7:0]      rspData,
  output logic            rspValid,
  output logic            rspLast,
  output logic            busy
);
  if (SETUP_CYC < 1 || SETUP_CYC > 255 || GAP_CYC < 1 || GAP_CYC > 255) begin : g_chk
    $error("SETUP_CYC or GAP_CYC out of range");
  end

  localparam logic [7:0] SETUP_LD = 8'(SETUP_CYC);
  localparam logic [7:0] GAP_LD   = 8'(GAP_CYC);

  smc_pkg::smc_host_state_t state_q;
  logic [7:0]  timer_q;
  logic [31:0] cnt_q;
  logic [31:0] len_q;
  logic        csN_q;
  logic        inFl_q;
  logic        lastIss_q;
  logic        cmdTaken_q;
  logic [7:0]  rspData_q;
  logic        rspValid_q;
  logic        rspLast_q;
  logic        busy_q;
  logic        startNow;
  logic        canStart;
  logic [7:0]  txB;
  logic [7:0]  lenB;
  logic [31:0] cnt1;
  logic [31:0] lenNow;
  logic        engDone;
  logic [7:0]  engRx;
  logic        engSclk;
  logic        engMosi;

  smc_byte_engine u_eng (
    .clk    (clk),
    .rst_n  (rst_n),
    .ce     (ce),
    .start  (startNow),
    .txByte (txB),
    .miso   (link.miso),
    .busy   (),
    .done   (engDone),
    .rxByte (engRx),
    .sclk   (engSclk),
    .mosi   (engMosi)
  );

  assign link.sclk = engSclk;
  assign link.mosi = engMosi;
  assign link.csN  = csN_q;
  assign cmdTaken  = cmdTaken_q;
  assign rspData   = rspData_q;
  assign rspValid  = rspValid_q;
  assign rspLast   = rspLast_q;
  assign busy      = busy_q;

  assign cnt1   = cnt_q + 32'h1;
  assign lenB   = (state_q == smc_pkg::H_READ) ? engRx : cmdData;
  assign lenNow = smc_pkg::smc_len_next(cnt_q, len_q, lenB);

  // ------------------------------------------------------------
  // byte issue
  // ------------------------------------------------------------
  always_comb begin
    canStart = (timer_q == 8'h00) && !csN_q && !inFl_q;
    startNow = 1'b0;
    txB      = smc_pkg::FILL_BYTE;
    case (state_q)
      smc_pkg::H_CMD: begin
        startNow = canStart && cmdValid;
        txB      = cmdData;
      end
      smc_pkg::H_POLL: begin
        startNow = canStart;
        txB      = smc_pkg::STATUS_WAIT;
      end
      smc_pkg::H_READ: startNow = canStart;
      smc_pkg::H_ACC: begin
        startNow = canStart;
        txB      = smc_pkg::ACCEPT_BYTE;
      end
      default: startNow = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // frame sequencing
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= smc_pkg::H_IDLE;
      timer_q    <= 8'h00;
      cnt_q      <= 32'h0;
      len_q      <= 32'h0;
      csN_q      <= 1'b1;
      inFl_q     <= 1'b0;
      lastIss_q  <= 1'b0;
      cmdTaken_q <= 1'b0;
      rspData_q  <= 8'h00;
      rspValid_q <= 1'b0;
      rspLast_q  <= 1'b0;
      busy_q     <= 1'b0;
    end else if (ce) begin
      cmdTaken_q <= 1'b0;
      rspValid_q <= 1'b0;
      rspLast_q  <= 1'b0;
      if (timer_q != 8'h00) begin
        timer_q <= timer_q - 8'h01;
      end
      if (startNow) begin
        inFl_q <= 1'b1;
      end else if (engDone) begin
        inFl_q <= 1'b0;
      end
      case (state_q)
        smc_pkg::H_IDLE: begin
          if (timer_q == 8'h00 && cmdValid) begin
            state_q   <= smc_pkg::H_CMD;
            csN_q     <= 1'b0;
            timer_q   <= SETUP_LD;
            cnt_q     <= 32'h0;
            len_q     <= 32'h0;
            lastIss_q <= 1'b0;
            busy_q    <= 1'b1;
          end
        end
        smc_pkg::H_CMD: begin
          if (startNow) begin
            cmdTaken_q <= 1'b1;
            cnt_q      <= cnt1;
            len_q      <= lenNow;
            lastIss_q  <= smc_pkg::smc_is_last(cnt1, lenNow);
          end
          if (engDone && lastIss_q) begin
            state_q <= smc_pkg::H_POLL;
            csN_q   <= 1'b1;
            timer_q <= GAP_LD;
          end
        end
        smc_pkg::H_POLL: begin
          if (csN_q && timer_q == 8'h00) begin
            csN_q   <= 1'b0;
            timer_q <= SETUP_LD;
          end
          if (engDone) begin
            if (engRx == smc_pkg::STATUS_DATA) begin
              state_q <= smc_pkg::H_READ;
              cnt_q   <= 32'h0;
              len_q   <= 32'h0;
            end else begin
              // wait state: drop the frame and poll again
              csN_q   <= 1'b1;
              timer_q <= GAP_LD;
            end
          end
        end
        smc_pkg::H_READ: begin
          if (engDone) begin
            rspData_q  <= engRx;
            rspValid_q <= 1'b1;
            cnt_q      <= cnt1;
            len_q      <= lenNow;
            if (smc_pkg::smc_is_last(cnt1, lenNow)) begin
              rspLast_q <= 1'b1;
              state_q   <= smc_pkg::H_ACC;
              csN_q     <= 1'b1;
              timer_q   <= GAP_LD;
            end
          end
        end
        smc_pkg::H_ACC: begin
          if (csN_q && timer_q == 8'h00) begin
            csN_q   <= 1'b0;
            timer_q <= SETUP_LD;
          end
          if (engDone) begin
            state_q <= smc_pkg::H_IDLE;
            csN_q   <= 1'b1;
            timer_q <= GAP_LD;
            busy_q  <= 1'b0;
          end
        end
        default: state_q <= smc_pkg::H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: verilog/smc_dev_end.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - both headers are exactly ten bytes
// - command header: tag, length, operation code
// - request length counts every command byte
// - host sends payload until request length reached
// - frame ends by length and chip select high
// - device does not idle by itself after a complete frame
// - host starts each frame with chip select low
// - reply header: tag, reply length, result code
// - reply output until reply length, payload optional
// - idle only after last byte and accept bit; code also idles on a short command frame (cmdAbort)
// - idle device may run background work
// - bus activity aborts background work at once
// - bits shifted MSB first both directions
// - device is slave, never drives clock or select
// - device may insert wait states, host honours
module smc_dev_end (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  smc_link_if.dev         link,
  output logic [7:0]      cmdData,
  output logic            cmdValid,
  output logic            cmdFirst,
  output logic            cmdLast,
  output logic            cmdAbort,
  input  wire logic [7:0] rspData,
  input  wire logic       rspValid,
  output logic            rspTaken,
  output logic            idle,
  output logic            bgActive,
  output logic            bgAbort
);
  // ------------------------------------------------------------
  // link domain, clocked by the host serial clock
  // ------------------------------------------------------------
  logic       linkRstN;
  logic [2:0] bitCnt_q;
  logic [7:0] rxSh_q;
  logic [7:0] rxByte_q;
  logic       rxTgl_q;
  logic [7:0] txSh_q;
  logic       miso_q;
  logic       takeTgl_q;
  logic [7:0] txNext_q;

  // select high clears the bit position; sclk is idle then, so release is quiet
  assign linkRstN  = rst_n & ~link.csN;
  assign link.miso = miso_q;

  always_ff @(negedge link.sclk or negedge linkRstN) begin
    if (!linkRstN) begin
      bitCnt_q <= 3'h0;
      rxSh_q   <= 8'h00;
    end else begin
      rxSh_q   <= {rxSh_q[6:0], link.mosi};
      bitCnt_q <= bitCnt_q + 3'h1;
    end
  end

  // toggles survive the frame boundary, only rst_n clears them
  always_ff @(negedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      rxByte_q <= 8'h00;
      rxTgl_q  <= 1'b0;
    end else if (bitCnt_q == 3'h7) begin
      rxByte_q <= {rxSh_q[6:0], link.mosi};
      rxTgl_q  <= ~rxTgl_q;
    end
  end

  // txNext_q is held stable for a whole byte before it is taken here
  always_ff @(posedge link.sclk or negedge linkRstN) begin
    if (!linkRstN) begin
      txSh_q <= 8'h00;
      miso_q <= 1'b0;
    end else if (bitCnt_q == 3'h0) begin
      miso_q <= txNext_q[7];
      txSh_q <= {txNext_q[6:0], 1'b0};
    end else begin
      miso_q <= txSh_q[7];
      txSh_q <= {txSh_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      takeTgl_q <= 1'b0;
    end else if (bitCnt_q == 3'h0) begin
      takeTgl_q <= ~takeTgl_q;
    end
  end

  // ------------------------------------------------------------
  // crossing into the system clock
  // ------------------------------------------------------------
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] syIn;
  logic       rxEv;
  logic       takeEv;
  logic       csHigh;
  logic       frameEnd;

  always_comb begin
    syIn                 = 3'h0;
    syIn[smc_pkg::SY_RX]   = rxTgl_q;
    syIn[smc_pkg::SY_TAKE] = takeTgl_q;
    syIn[smc_pkg::SY_CS]   = link.csN;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 3'h4;
      s2_q <= 3'h4;
      s3_q <= 3'h4;
    end else if (ce) begin
      s1_q <= syIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign rxEv     = s2_q[smc_pkg::SY_RX] ^ s3_q[smc_pkg::SY_RX];
  assign takeEv   = s2_q[smc_pkg::SY_TAKE] ^ s3_q[smc_pkg::SY_TAKE];
  assign csHigh   = s2_q[smc_pkg::SY_CS];
  assign frameEnd = csHigh & ~s3_q[smc_pkg::SY_CS];

  // ------------------------------------------------------------
  // framing
  // ------------------------------------------------------------
  smc_pkg::smc_dev_state_t state_q;
  logic [31:0] cnt_q;
  logic [31:0] len_q;
  logic [31:0] cnt1;
  logic [31:0] lenNow;
  logic [7:0]  lenB;
  logic        rxDone_q;
  logic        txDone_q;
  logic        acc_q;
  logic        idle_q;
  logic [7:0]  cmdData_q;
  logic        cmdValid_q;
  logic        cmdFirst_q;
  logic        cmdLast_q;
  logic        cmdAbort_q;

  assign cnt1   = cnt_q + 32'h1;
  assign lenB   = (state_q == smc_pkg::D_TXRSP) ? rspData : rxByte_q;
  assign lenNow = smc_pkg::smc_len_next(cnt_q, len_q, lenB);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= smc_pkg::D_IDLE;
      cnt_q      <= 32'h0;
      len_q      <= 32'h0;
      rxDone_q   <= 1'b0;
      txDone_q   <= 1'b0;
      acc_q      <= 1'b0;
      idle_q     <= 1'b1;
      cmdData_q  <= 8'h00;
      cmdValid_q <= 1'b0;
      cmdFirst_q <= 1'b0;
      cmdLast_q  <= 1'b0;
      cmdAbort_q <= 1'b0;
    end else if (ce) begin
      cmdValid_q <= 1'b0;
      cmdFirst_q <= 1'b0;
      cmdLast_q  <= 1'b0;
      cmdAbort_q <= 1'b0;
      case (state_q)
        smc_pkg::D_IDLE: begin
          if (rxEv) begin
            state_q    <= smc_pkg::D_RXCMD;
            idle_q     <= 1'b0;
            cmdFirst_q <= 1'b1;
            cmdValid_q <= 1'b1;
            cmdData_q  <= rxByte_q;
            cnt_q      <= 32'h1;
            len_q      <= 32'h0;
            rxDone_q   <= 1'b0;
          end
        end
        smc_pkg::D_RXCMD: begin
          // bytes past the request length are dropped
          if (rxEv && !rxDone_q) begin
            cmdValid_q <= 1'b1;
            cmdData_q  <= rxByte_q;
            cnt_q      <= cnt1;
            len_q      <= lenNow;
            if (smc_pkg::smc_is_last(cnt1, lenNow)) begin
              cmdLast_q <= 1'b1;
              rxDone_q  <= 1'b1;
            end
          end
          if (frameEnd) begin
            if (rxDone_q) begin
              state_q <= smc_pkg::D_EXEC;
            end else begin
              state_q    <= smc_pkg::D_IDLE;
              idle_q     <= 1'b1;
              cmdAbort_q <= 1'b1;
            end
          end
        end
        smc_pkg::D_EXEC: begin
          if (takeEv && txNext_q == smc_pkg::STATUS_DATA) begin
            state_q  <= smc_pkg::D_TXRSP;
            // byte 0 is loaded here, so cnt_q tracks the byte now on rspData
            cnt_q    <= 32'h1;
            len_q    <= 32'h0;
            txDone_q <= 1'b0;
          end
        end
        smc_pkg::D_TXRSP: begin
          if (takeEv && !txDone_q) begin
            cnt_q <= cnt1;
            len_q <= lenNow;
            if (smc_pkg::smc_is_last(cnt1, lenNow)) begin
              txDone_q <= 1'b1;
            end
          end
          if (frameEnd) begin
            state_q <= smc_pkg::D_ACC;
            acc_q   <= 1'b0;
          end
        end
        smc_pkg::D_ACC: begin
          if (rxEv && (rxByte_q & smc_pkg::ACCEPT_BYTE) != 8'h00) begin
            acc_q <= 1'b1;
          end
          if (frameEnd && acc_q && txDone_q) begin
            state_q <= smc_pkg::D_IDLE;
            idle_q  <= 1'b1;
          end
        end
        default: begin
          state_q <= smc_pkg::D_IDLE;
          idle_q  <= 1'b1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // next byte for the link; first byte of a frame is status
  // ------------------------------------------------------------
  logic loadRsp;
  logic rspTaken_q;

  assign loadRsp = (state_q == smc_pkg::D_EXEC && txNext_q == smc_pkg::STATUS_DATA)
                 || (state_q == smc_pkg::D_TXRSP && !txDone_q);

  // status flips in one bit only, so a late change while select falls is benign
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txNext_q   <= smc_pkg::STATUS_WAIT;
      rspTaken_q <= 1'b0;
    end else if (ce) begin
      rspTaken_q <= 1'b0;
      if (csHigh) begin
        txNext_q <= (state_q == smc_pkg::D_EXEC && rspValid) ? smc_pkg::STATUS_DATA
                                                             : smc_pkg::STATUS_WAIT;
      end else if (takeEv) begin
        if (loadRsp) begin
          txNext_q   <= rspData;
          rspTaken_q <= 1'b1;
        end else if (state_q == smc_pkg::D_TXRSP) begin
          txNext_q <= smc_pkg::FILL_BYTE;
        end else begin
          txNext_q <= smc_pkg::STATUS_WAIT;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // background work while idle
  // ------------------------------------------------------------
  logic bgActive_q;
  logic bgAbort_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bgActive_q <= 1'b0;
      bgAbort_q  <= 1'b0;
    end else if (ce) begin
      bgAbort_q <= 1'b0;
      if (bgActive_q && (!csHigh || state_q != smc_pkg::D_IDLE)) begin
        bgActive_q <= 1'b0;
        bgAbort_q  <= 1'b1;
      end else if (state_q == smc_pkg::D_IDLE && csHigh) begin
        bgActive_q <= 1'b1;
      end
    end
  end

  assign cmdData  = cmdData_q;
  assign cmdValid = cmdValid_q;
  assign cmdFirst = cmdFirst_q;
  assign cmdLast  = cmdLast_q;
  assign cmdAbort = cmdAbort_q;
  assign rspTaken = rspTaken_q;
  assign idle     = idle_q;
  assign bgActive = bgActive_q;
  assign bgAbort  = bgAbort_q;
endmodule
`default_nettype wire

// file: test/smc_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module smc_link_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic miso
);
  logic [2:0] edgeCnt_q;

  // ----------------------------------------
  // bit count within a frame
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edgeCnt_q <= 3'h0;
    end else if (csN) begin
      edgeCnt_q <= 3'h0;
    end else if ($rose(sclk)) begin
      edgeCnt_q <= edgeCnt_q + 3'h1;
    end
  end

  // ----------------------------------------
  // link timing
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence sclkHigh;
    sclk[*4] ##1 !sclk;
  endsequence

  sequence sclkLow;
    !sclk[*4];
  endsequence

  sclk_idle_low_a: assert property (csN |-> !sclk)
    else $error("sclk moves outside a frame");
  cs_setup_a: assert property ($fell(csN) |-> !sclk[*6])
    else $error("sclk too soon after select");
  cs_gap_a: assert property ($rose(csN) |-> csN[*6])
    else $error("select gap too short");
  sclk_high_a: assert property ($rose(sclk) |-> sclkHigh)
    else $error("sclk high phase wrong");
  sclk_low_a: assert property ($fell(sclk) |-> sclkLow)
    else $error("sclk low phase short");
  mosi_hold_a: assert property ($rose(sclk) |=> $stable(mosi)[*3])
    else $error("mosi moved before sampling");
  miso_hold_a: assert property ($rose(sclk) |=> $stable(miso)[*3])
    else $error("miso moved before sampling");
  byte_whole_a: assert property ($rose(csN) |-> edgeCnt_q == 3'h0)
    else $error("frame ended mid byte");
endmodule
`default_nettype wire

// file: test/secure_module_cmd_framer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module secure_module_cmd_framer_tb;
  typedef logic [7:0] smc_bq_t[$];
  logic       clk       = 1'b0;
  logic       rst_n     = 1'b0;
  logic [7:0] hCmdData  = 8'h00;
  logic       hCmdValid = 1'b0;
  logic [7:0] dRspData  = 8'h00;
  logic       dRspValid = 1'b0;
  logic [7:0] hRspData, dCmdData;
  logic       hCmdTaken, hRspValid, hRspLast, hBusy, idleAtLast;
  logic       dCmdValid, dCmdFirst, dCmdLast, dCmdAbort, dRspTaken, dIdle, dBgActive, dBgAbort;
  logic [9:0] gotCmd[$];
  logic [8:0] gotRsp[$];
  smc_bq_t    rsp;
  int         rIdx, aborts, cmdAborts, errors, cmp_count;

  always #12.5 clk = ~clk;

  smc_link_if smc_link_if_i ();
  smc_host_end #(.SETUP_CYC(8), .GAP_CYC(8)) smc_host_end_i (.clk(clk), .rst_n(rst_n),
    .ce(1'b1), .link(smc_link_if_i), .cmdData(hCmdData), .cmdValid(hCmdValid),
    .cmdTaken(hCmdTaken), .rspData(hRspData), .rspValid(hRspValid), .rspLast(hRspLast),
    .busy(hBusy));
  smc_dev_end smc_dev_end_i (.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(smc_link_if_i),
    .cmdData(dCmdData), .cmdValid(dCmdValid), .cmdFirst(dCmdFirst), .cmdLast(dCmdLast),
    .cmdAbort(dCmdAbort), .rspData(dRspData), .rspValid(dRspValid), .rspTaken(dRspTaken),
    .idle(dIdle), .bgActive(dBgActive), .bgAbort(dBgAbort));
  smc_link_checker smc_link_checker_i (.clk(clk), .rst_n(rst_n), .sclk(smc_link_if_i.sclk),
    .csN(smc_link_if_i.csN), .mosi(smc_link_if_i.mosi), .miso(smc_link_if_i.miso));

  // ----------------------------------------
  // frames, monitors, device-side responder
  // ----------------------------------------
  function automatic smc_bq_t mk(logic [15:0] tag, logic [31:0] code, int n);
    smc_bq_t     q;
    logic [31:0] len;
    len = 32'(10 + n);
    q = {tag[15:8], tag[7:0]};
    for (int i = 3; i >= 0; i--) q.push_back(len[8*i+:8]);
    for (int i = 3; i >= 0; i--) q.push_back(code[8*i+:8]);
    for (int i = 0; i < n; i++) q.push_back(8'(8'hA5 ^ i));
    return q;
  endfunction

  always @(posedge clk) begin
    if (dCmdValid) gotCmd.push_back({dCmdFirst, dCmdLast, dCmdData});
    if (hRspValid) gotRsp.push_back({hRspLast, hRspData});
    if (hRspValid && hRspLast) idleAtLast = dIdle;
    if (dBgAbort) aborts++;
    if (dCmdAbort) cmdAborts++;
  end

  // not a fifo: the next byte must be up within one link byte
  always @(posedge clk) begin
    if (dCmdLast) begin
      #1 rIdx = 0;
      dRspData = rsp[0];
      dRspValid = 1'b1;
    end else if (dRspTaken) begin
      #1 rIdx++;
      dRspValid = rIdx < rsp.size();
      dRspData = dRspValid ? rsp[rIdx] : 8'h00;
    end
  end

  // ----------------------------------------
  // checking and scenarios
  // ----------------------------------------
  task automatic chk(logic [15:0] g, logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic run(smc_bq_t c, smc_bq_t r);
    int a0;
    int n;
    gotCmd = {};
    gotRsp = {};
    rsp = r;
    a0 = aborts;
    chk(16'(dBgActive), 16'h0001);
    foreach (c[i]) begin
      hCmdData = c[i];
      hCmdValid = 1'b1;
      for (n = 0; n < 400 && hCmdTaken !== 1'b1; n++) @(posedge clk);
      #1;
    end
    hCmdValid = 1'b0;
    for (n = 0; n < 20000 && hBusy !== 1'b0; n++) @(posedge clk);
    repeat (8) @(posedge clk);
    #1;
    chk(16'(gotCmd.size()), 16'(c.size()));
    foreach (c[i]) chk(16'(gotCmd[i]), 16'({i == 0, i == c.size() - 1, c[i]}));
    chk(16'(gotRsp.size()), 16'(r.size()));
    foreach (r[i]) chk(16'(gotRsp[i]), 16'({i == r.size() - 1, r[i]}));
    chk(16'(idleAtLast), 16'h0000);
    chk(16'({dIdle, dBgActive}), 16'h0003);
    chk(16'(aborts - a0), 16'h0001);
    chk(16'(cmdAborts), 16'h0000);
  endtask

  task automatic sc_bare_reply;
    run(mk(16'h8001, 32'h0000017A, 2), mk(16'h8001, 32'h00000000, 0));
  endtask

  task automatic sc_header_only_cmd;
    run(mk(16'h8002, 32'h0000014E, 0), mk(16'h8002, 32'h00000101, 13));
  endtask

  task automatic close_out;
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    sc_bare_reply();
    sc_header_only_cmd();
    close_out();
  end

  // both scenarios fit well inside this span
  initial begin
    #1500000;
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
